// ### rtl/art_timer.sv
// Auto-reload 16-bit timer/counter with control register and AXI4-Lite slave.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Source is clock/12 or external pin.
// - Sample external pin once per machine cycle.
// - Qualify bit gates counting with pin a.
// - Run bit enables; clear holds count.
// - High and low bytes form 16-bit counter.
// - Overflow loads count from reload registers.
// - Reload registers stay unchanged by reload.
// - Overflow flag set; cleared by vector, reset.
// - Enabled timer interrupt requests on status bit.
// - Edge on pin b sets pending b.
// - Control bits 3..0 pending/select layout.
//////////////////////////////////////////////////////////////////////////////
module art_timer (
    input  wire logic        core_clk_i,      // System clock, 200 MHz.
    input  wire logic        reset_i,         // Synchronous reset, active high.
    input  wire logic        count_pin_i,     // External count input pin.
    input  wire logic        ext_irq_a_i,     // External interrupt pin a.
    input  wire logic        ext_irq_b_i,     // External interrupt pin b.
    input  wire logic        s_axi_awvalid,   // Write address valid.
    output logic             s_axi_awready,   // Write address ready.
    input  wire logic [7:0]  s_axi_awaddr,    // Write address.
    input  wire logic        s_axi_wvalid,    // Write data valid.
    output logic             s_axi_wready,    // Write data ready.
    input  wire logic [31:0] s_axi_wdata,     // Write data.
    input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes.
    output logic             s_axi_bvalid,    // Write response valid.
    input  wire logic        s_axi_bready,    // Write response ready.
    output logic [1:0]       s_axi_bresp,     // Write response.
    input  wire logic        s_axi_arvalid,   // Read address valid.
    output logic             s_axi_arready,   // Read address ready.
    input  wire logic [7:0]  s_axi_araddr,    // Read address.
    output logic             s_axi_rvalid,    // Read data valid.
    input  wire logic        s_axi_rready,    // Read data ready.
    output logic [31:0]      s_axi_rdata,     // Read data.
    output logic [1:0]       s_axi_rresp,     // Read response.
    output logic             irq_o,           // Level interrupt output.
    output logic             tick_o           // Registered counter tick strobe.
);
    logic [7:0]  control;
    logic [15:0] count;
    logic [15:0] reload;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [3:0]  prescale;
    logic [2:0]  sync1, sync2, sync3;
    art_pkg::art_pins_s pins, pins_prev;
    logic        sample_en;
    logic        count_sample, count_sample_prev;
    logic        tick;
    logic        ovf;
    logic        edge_a, edge_b, set_a, set_b;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_held, w_held;
    logic        wr_fire;
    logic        wr_control, wr_count, wr_reload, wr_status, wr_mask, wr_ack;

    // Decode a register offset into a one-hot strobe; used for both channels.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; a level is accepted once stages two and three agree.
    always_ff @(posedge core_clk_i) begin
        sync1 <= {count_pin_i, ext_irq_a_i, ext_irq_b_i};
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // Filtered pin levels; a glitch seen by only one stage is ignored.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pins      <= '1; // Pins idle high; a low reset value would fake a level request.
            pins_prev <= '1;
        end else begin
            if (sync2 == sync3) begin
                pins <= sync3;
            end
            pins_prev <= pins;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Divide by twelve; the wrap is the internal tick.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            prescale <= 4'h0;
        end else if (prescale == art_pkg::PRESCALE_LAST) begin
            prescale <= 4'h0;
        end else begin
            prescale <= prescale + 4'h1;
        end
    end
    assign sample_en = (prescale == art_pkg::SAMPLE_SLOT);

    // External pin sampled once per machine cycle; a falling edge between samples counts.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            count_sample      <= 1'b1; // Idle level of the pin, so no false fall after reset.
            count_sample_prev <= 1'b1;
        end else if (sample_en) begin
            count_sample      <= pins.count_in;
            count_sample_prev <= count_sample;
        end
    end

    // Tick selection and qualification.
    always_comb begin
        if (control[art_pkg::BIT_SRC_EXT]) begin
            tick = sample_en && count_sample_prev && !count_sample;
        end else begin
            tick = (prescale == art_pkg::PRESCALE_LAST);
        end
        tick = tick && control[art_pkg::BIT_RUN]
               && (!control[art_pkg::BIT_QUALIFY] || pins.irq_a);
    end
    assign ovf = tick && (count == 16'hFFFF);

    //////////////////////////////////////////////////////////////////////////
    // Counter; software writes win only when no tick lands in that cycle.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            count <= art_pkg::COUNT_RESET;
        end else if (ovf) begin
            count <= reload;
        end else if (tick) begin
            count <= count + 16'h0001;
        end else if (wr_count) begin
            if (w_strb[0]) count[7:0]  <= w_data[7:0];
            if (w_strb[1]) count[15:8] <= w_data[15:8];
        end
    end

    // Reload pair changes only by software; the reload path only reads it.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            reload <= art_pkg::RELOAD_RESET;
        end else if (wr_reload) begin
            if (w_strb[0]) reload[7:0]  <= w_data[7:0];
            if (w_strb[1]) reload[15:8] <= w_data[15:8];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // External interrupt detection: edge mode on falling edge, level mode while low.
    assign edge_a = pins_prev.irq_a && !pins.irq_a;
    assign edge_b = pins_prev.irq_b && !pins.irq_b;
    assign set_a  = control[art_pkg::BIT_A_EDGE_SEL] ? edge_a : !pins.irq_a;
    assign set_b  = control[art_pkg::BIT_B_EDGE_SEL] ? edge_b : !pins.irq_b;

    // Control register; hardware sets win over software and vector clears.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            control <= art_pkg::CONTROL_RESET;
        end else begin
            if (wr_control && w_strb[0]) begin
                control <= w_data[7:0];
            end
            if (wr_ack && w_strb[0] && w_data[art_pkg::IRQ_OVF]) begin
                control[art_pkg::BIT_OVERFLOW] <= 1'b0;
            end
            if (ovf) begin
                control[art_pkg::BIT_OVERFLOW] <= 1'b1;
            end
            if (set_a) begin
                control[art_pkg::BIT_A_PENDING] <= 1'b1;
            end
            if (set_b) begin
                control[art_pkg::BIT_B_PENDING] <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sticky status, write one to clear; a new event in the same cycle wins.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (irq_status & ~((wr_status && w_strb[0]) ? w_data[2:0] : 3'h0))
                          | {set_b, set_a, ovf};
        end
    end

    // Mask register and level interrupt output.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_mask <= art_pkg::MASK_RESET;
            irq_o    <= 1'b0;
            tick_o   <= 1'b0;
        end else begin
            if (wr_mask && w_strb[0]) irq_mask <= w_data[2:0];
            irq_o  <= |(irq_status & irq_mask);
            tick_o <= tick;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order, response after both.
    assign wr_fire    = aw_held && w_held && !s_axi_bvalid;
    assign wr_control = wr_fire && hit(aw_addr, art_pkg::ADDR_CONTROL);
    assign wr_count   = wr_fire && hit(aw_addr, art_pkg::ADDR_COUNT);
    assign wr_reload  = wr_fire && hit(aw_addr, art_pkg::ADDR_RELOAD);
    assign wr_status  = wr_fire && hit(aw_addr, art_pkg::ADDR_IRQ_STATUS);
    assign wr_mask    = wr_fire && hit(aw_addr, art_pkg::ADDR_IRQ_MASK);
    assign wr_ack     = wr_fire && hit(aw_addr, art_pkg::ADDR_VECTOR_ACK);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= art_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_control || wr_count || wr_reload || wr_status || wr_mask || wr_ack)
                                ? art_pkg::RESP_OKAY : art_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, data registered one cycle after the address.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= art_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= art_pkg::RESP_OKAY;
                if (hit(s_axi_araddr, art_pkg::ADDR_CONTROL)) begin
                    s_axi_rdata <= {24'h000000, control};
                end else if (hit(s_axi_araddr, art_pkg::ADDR_COUNT)) begin
                    s_axi_rdata <= {16'h0000, count};
                end else if (hit(s_axi_araddr, art_pkg::ADDR_RELOAD)) begin
                    s_axi_rdata <= {16'h0000, reload};
                end else if (hit(s_axi_araddr, art_pkg::ADDR_IRQ_STATUS)) begin
                    s_axi_rdata <= {29'h0000000, irq_status};
                end else if (hit(s_axi_araddr, art_pkg::ADDR_IRQ_MASK)) begin
                    s_axi_rdata <= {29'h0000000, irq_mask};
                end else if (hit(s_axi_araddr, art_pkg::ADDR_VECTOR_ACK)) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= art_pkg::RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks on the counting path and flags.
    property p_hold_when_stopped;
        @(posedge core_clk_i) disable iff (reset_i)
        !control[art_pkg::BIT_RUN] && !wr_count |=> count == $past(count);
    endproperty
    a_hold_when_stopped: assert property (p_hold_when_stopped) else $error("count moved while stopped");

    property p_increment;
        @(posedge core_clk_i) disable iff (reset_i)
        tick && count != 16'hFFFF |=> count == $past(count) + 16'h0001;
    endproperty
    a_increment: assert property (p_increment) else $error("count did not increment");

    property p_reload;
        @(posedge core_clk_i) disable iff (reset_i)
        ovf |=> count == $past(reload) && control[art_pkg::BIT_OVERFLOW];
    endproperty
    a_reload: assert property (p_reload) else $error("overflow did not reload or flag");

    property p_reload_kept;
        @(posedge core_clk_i) disable iff (reset_i)
        ovf && !wr_reload |=> $stable(reload);
    endproperty
    a_reload_kept: assert property (p_reload_kept) else $error("reload changed on overflow");

    property p_internal_rate;
        @(posedge core_clk_i) disable iff (reset_i)
        tick && !control[art_pkg::BIT_SRC_EXT] |=> !tick [*8] ##1 !tick ##1 !tick ##1 !tick;
    endproperty
    a_internal_rate: assert property (p_internal_rate) else $error("internal tick faster than 1/12");

    property p_qualify;
        @(posedge core_clk_i) disable iff (reset_i)
        control[art_pkg::BIT_QUALIFY] && !pins.irq_a |-> !tick;
    endproperty
    a_qualify: assert property (p_qualify) else $error("counted with qualify pin low");

    property p_sample_once;
        @(posedge core_clk_i) disable iff (reset_i)
        tick && control[art_pkg::BIT_SRC_EXT] |-> sample_en;
    endproperty
    a_sample_once: assert property (p_sample_once) else $error("external tick off sample phase");

    property p_irq;
        @(posedge core_clk_i) disable iff (reset_i)
        ovf && irq_mask[art_pkg::IRQ_OVF] |-> ##2 irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("masked-in overflow raised no interrupt");

    property p_edge_b;
        @(posedge core_clk_i) disable iff (reset_i)
        control[art_pkg::BIT_B_EDGE_SEL] && edge_b |=> control[art_pkg::BIT_B_PENDING];
    endproperty
    a_edge_b: assert property (p_edge_b) else $error("edge on pin b not flagged");

    c_overflow: cover property (@(posedge core_clk_i) disable iff (reset_i) ovf);
    c_ext_tick: cover property (@(posedge core_clk_i) disable iff (reset_i)
                                tick && control[art_pkg::BIT_SRC_EXT]);
    c_irq: cover property (@(posedge core_clk_i) disable iff (reset_i) $rose(irq_o));
endmodule

// ### rtl/art_pkg.sv
// Package with register map, field positions and timing constants of the reload timer.
package art_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] ADDR_CONTROL     = 8'h00;
    localparam logic [7:0] ADDR_COUNT       = 8'h04;
    localparam logic [7:0] ADDR_RELOAD      = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h10;
    localparam logic [7:0] ADDR_VECTOR_ACK  = 8'h14;
    // Control register field positions.
    localparam int BIT_QUALIFY    = 7;
    localparam int BIT_SRC_EXT    = 6;
    localparam int BIT_OVERFLOW   = 5;
    localparam int BIT_RUN        = 4;
    localparam int BIT_A_PENDING  = 3;
    localparam int BIT_A_EDGE_SEL = 2;
    localparam int BIT_B_PENDING  = 1;
    localparam int BIT_B_EDGE_SEL = 0;
    // Status bits: 0 overflow, 1 ext a, 2 ext b.
    localparam int IRQ_OVF = 0;
    localparam int IRQ_A   = 1;
    localparam int IRQ_B   = 2;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] RELOAD_RESET  = 16'h0000;
    localparam logic [2:0]  MASK_RESET    = 3'h0;
    // Internal tick is one twelfth of the core clock.
    localparam int          PRESCALE      = 12;
    localparam logic [3:0]  PRESCALE_LAST = 4'(PRESCALE - 1);
    // Sample phase slot within the twelve-cycle machine cycle.
    localparam logic [3:0]  SAMPLE_SLOT   = 4'h6;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Synchronised pin levels travel together.
    typedef struct packed {
        logic count_in;
        logic irq_a;
        logic irq_b;
    } art_pins_s;
endpackage

// ### bench/art_timer_tb.sv
// Self-checking testbench for the auto-reload timer through its bus and pins.
`timescale 1ns/100ps
module art_timer_tb;
    logic        core_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        count_pin_i = 1'b1;
    logic        ext_irq_a_i = 1'b1;
    logic        ext_irq_b_i = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq_o, tick_o;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp;
    int          failures = 0, samples_checked = 0, cyc = 0, ticks = 0;

    art_timer dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .count_pin_i(count_pin_i),
        .ext_irq_a_i(ext_irq_a_i), .ext_irq_b_i(ext_irq_b_i),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .irq_o(irq_o), .tick_o(tick_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // The clock toggles every half period of 2.5 ns.
    always #2.5 core_clk_i = ~core_clk_i;

    // Ticks are counted on the falling edge so the count never races the scenario code.
    always @(negedge core_clk_i) begin
        if (tick_o === 1'b1) begin
            ticks++;
        end
    end

    // A hung handshake would stall forever, so a cycle ceiling cuts the run short.
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // Address and data are offered together; each is dropped only at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk_i);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        bready <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk_i);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Every register reads zero after reset; unmapped places answer with an error.
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), d, r);
            chk(d, 32'h0, "reset value");
            chk({30'h0, r}, {30'h0, art_pkg::RESP_OKAY}, "read resp");
        end
        rd(8'h18, d, r);
        chk({d[29:0], r}, {30'h0, art_pkg::RESP_SLVERR}, "unmapped read");
        wr(8'h1C, 32'hFFFF_FFFF, r);
        chk({30'h0, r}, {30'h0, art_pkg::RESP_SLVERR}, "unmapped write");
    endtask

    // Internal ticks wrap through all ones into the reload value and raise the flag.
    task automatic t_timer();
        logic [31:0] d, e;
        logic [1:0]  r;
        int          t0, n, k;
        wr(8'h08, 32'h0000_1234, r);
        wr(8'h04, 32'h0000_FFFD, r);
        t0 = ticks;
        wr(8'h00, 32'h0000_0010, r);
        k = 0;
        while (tick_o !== 1'b1 && k < 40) begin
            @(posedge core_clk_i);
            k++;
        end
        k = 0;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (tick_o !== 1'b1 && k < 40);
        chk(32'(k), 32'(art_pkg::PRESCALE), "tick spacing");
        while (ticks - t0 < 4) @(posedge core_clk_i);
        rd(8'h00, d, r);
        chk({24'h0, d[7:0]}, 32'h30, "flag after wrap");
        // Stop the count but keep the flag, so that the vector clear below has work to do.
        wr(8'h00, 32'h20, r);
        cycles(4);
        n = ticks - t0;
        e = (n < 3) ? 32'(16'hFFFD + n) : 32'(16'h1234 + n - 3);
        rd(8'h04, d, r);
        chk(d, e, "count after wrap");
        cycles(40);
        rd(8'h04, d, r);
        chk(d, e, "count held when stopped");
        rd(8'h08, d, r);
        chk(d, 32'h1234, "reload kept");
        chk({31'h0, irq_o}, 32'h0, "irq masked");
        wr(8'h10, 32'h1, r);
        cycles(3);
        chk({31'h0, irq_o}, 32'h1, "irq unmasked");
        rd(8'h00, d, r);
        chk({31'h0, d[art_pkg::BIT_OVERFLOW]}, 32'h1, "flag kept until vector");
        wr(8'h14, 32'h1, r);
        rd(8'h00, d, r);
        chk({31'h0, d[art_pkg::BIT_OVERFLOW]}, 32'h0, "vector clears flag");
        wr(8'h0C, 32'h1, r);
        cycles(3);
        chk({31'h0, irq_o}, 32'h0, "irq cleared");
        wr(8'h10, 32'h0, r);
    endtask

    // The qualify bit lets pin a gate counting; with it clear pin a has no say.
    task automatic t_qualify();
        logic [1:0] r;
        int         t0;
        ext_irq_a_i <= 1'b0;
        wr(8'h00, 32'h90, r);
        cycles(10);
        t0 = ticks;
        cycles(60);
        chk(32'(ticks - t0), 32'd0, "gated off");
        ext_irq_a_i <= 1'b1;
        cycles(10);
        t0 = ticks;
        cycles(60);
        chk(32'(ticks - t0), 32'd5, "gated on");
        ext_irq_a_i <= 1'b0;
        wr(8'h00, 32'h10, r);
        cycles(10);
        t0 = ticks;
        cycles(60);
        chk(32'(ticks - t0), 32'd5, "ungated");
        wr(8'h00, 32'h0, r);
        ext_irq_a_i <= 1'b1;
    endtask

    // In counter mode only falling transitions of the count pin advance the count.
    task automatic t_ext();
        logic [1:0] r;
        int         t0;
        wr(8'h00, 32'h50, r);
        t0 = ticks;
        cycles(60);
        chk(32'(ticks - t0), 32'd0, "no internal ticks");
        repeat (5) begin
            count_pin_i <= 1'b0;
            cycles(30);
            count_pin_i <= 1'b1;
            cycles(30);
        end
        cycles(20);
        chk(32'(ticks - t0), 32'd5, "pin falls counted");
        wr(8'h00, 32'h0, r);
    endtask

    // Edge modes of both interrupt pins and level mode of pin a land in their pending bits.
    task automatic t_extirq();
        logic [31:0] d;
        logic [1:0]  r;
        // Status bits left by the level-mode gating test are cleared first.
        wr(8'h0C, 32'h7, r);
        wr(8'h00, 32'h05, r);
        ext_irq_b_i <= 1'b0;
        cycles(30);
        ext_irq_b_i <= 1'b1;
        cycles(10);
        rd(8'h00, d, r);
        chk({24'h0, d[7:0]}, 32'h07, "pin b edge");
        ext_irq_a_i <= 1'b0;
        cycles(30);
        ext_irq_a_i <= 1'b1;
        cycles(10);
        rd(8'h00, d, r);
        chk({24'h0, d[7:0]}, 32'h0F, "pin a edge");
        rd(8'h0C, d, r);
        chk({30'h0, d[2:1]}, 32'h3, "status a b");
        wr(8'h00, 32'h0, r);
        ext_irq_a_i <= 1'b0;
        cycles(10);
        rd(8'h00, d, r);
        chk({31'h0, d[art_pkg::BIT_A_PENDING]}, 32'h1, "pin a level");
        ext_irq_a_i <= 1'b1;
        cycles(10);
        wr(8'h00, 32'h0, r);
        rd(8'h00, d, r);
        chk({24'h0, d[7:0]}, 32'h00, "pending cleared");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for sixteen cycles, then each scenario in turn.
    initial begin
        repeat (16) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_timer();
        t_qualify();
        t_ext();
        t_extirq();
        print_verdict();
    end
endmodule
